/* File: sram_bus_pkg.sv */
/*
  Constants shared by the pipelined burst SRAM bus model: widths, burst
  order encodings and the power-up wait.
  Assumes a 200 MHz system clock.
*/
package sram_bus_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DEPTH = 131072;
  localparam int BURST_W = 2;
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int POWER_WAIT_MS = 1;
  localparam int POWER_WAIT_CYC =
    (POWER_WAIT_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POWER_CNT_W = 18;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
endpackage

/* File: burst_addr_gen.sv */
/*
  Burst address sequencer: forms the low address bits of the current beat
  from the start offset and the beat count, linear or interleaved.
  Assumes the caller holds the beat count still during stall cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_addr_gen (
  // Burst state
  input wire logic [sram_bus_pkg::BURST_W-1:0] start_low,
  input wire logic [sram_bus_pkg::BURST_W-1:0] beat,
  input wire logic burst_order,
  // Resulting low address
  output logic [sram_bus_pkg::BURST_W-1:0] addr_low
);
  import sram_bus_pkg::*;

  always_comb begin
    if (burst_order == ORDER_INTERLEAVED) begin
      addr_low = start_low ^ beat;
    end else begin
      addr_low = start_low + beat;
    end
  end
endmodule
`default_nettype wire

/* File: sram_bus_core.sv */
/*
  Synchronous bus behaviour of a pipelined burst SRAM: select decode,
  burst ordering, clock-qualify stalls, sleep and the registered read path.
  Assumes a controller driving all pins on the same clock; the sleep and
  burst-order straps are pins and are synchronised here.
*/
// Operation
// - Selected only with first low, second high, third low.
// - Burst-order strap picks linear (0) or interleaved (1) burst order.
// - Deasserted clock qualify ignores the edge: no write, operation pauses.
// - Data pins are high impedance on leaving sleep.
// - High sleep request sleeps the memory and keeps contents intact.
`timescale 1ns/1ps
`default_nettype none
module sram_bus_core #(
  // Power-up wait in clock cycles; a bench may shorten it to keep runs brief.
  parameter int POWER_WAIT = sram_bus_pkg::POWER_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control pins
  input wire logic clock_qualify_n,
  input wire logic first_select_n,
  input wire logic second_select,
  input wire logic third_select_n,
  input wire logic advance_or_load,
  input wire logic write_enable_n,
  input wire logic [sram_bus_pkg::LANES-1:0] byte_write_lanes_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  // Address and data pins
  input wire logic [sram_bus_pkg::ADDR_W-1:0] addr,
  input wire logic [sram_bus_pkg::DATA_W-1:0] dq_in,
  output logic [sram_bus_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  // Status
  output logic power_ready,
  output logic asleep
);
  import sram_bus_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h4
  } op_t;

  logic [DATA_W-1:0] mem [DEPTH];
  logic sleep_s1_q, sleep_q, order_s1_q, order_q;
  logic [POWER_CNT_W-1:0] power_cnt_q;
  op_t op_q, op_d;
  logic [ADDR_W-1:0] base_q;
  logic [BURST_W-1:0] beat_q;
  logic [BURST_W-1:0] addr_low;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [LANES-1:0] wr_lanes_q;
  logic wr_pend_q, rd_pend_q;
  logic qualified, selected;

  // Straps arrive from pins and pass two flops before use.
  always_ff @(posedge clk) begin
    sleep_s1_q <= sleep_request;
    sleep_q <= sleep_s1_q;
    order_s1_q <= burst_order_strap;
    order_q <= order_s1_q;
  end

  // A flag for the controller only; the memory never refuses on it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_cnt_q <= '0;
    end else if (power_cnt_q != POWER_CNT_W'(POWER_WAIT)) begin
      power_cnt_q <= power_cnt_q + POWER_CNT_W'(1);
    end
  end
  assign power_ready = (power_cnt_q == POWER_CNT_W'(POWER_WAIT));
  assign asleep = sleep_q;

  assign selected = !first_select_n && second_select && !third_select_n;
  assign qualified = !clock_qualify_n && !sleep_q;

  always_comb begin
    op_d = op_q;
    if (advance_or_load == 1'b0) begin
      if (!selected) begin
        op_d = ST_IDLE;
      end else if (!write_enable_n) begin
        op_d = ST_WRITE;
      end else begin
        op_d = ST_READ;
      end
    end
  end

  // Burst state only moves on a qualified edge, so a stall pauses it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_q <= ST_IDLE;
      base_q <= '0;
      beat_q <= '0;
    end else if (qualified) begin
      op_q <= op_d;
      if (advance_or_load == 1'b0) begin
        base_q <= addr;
        beat_q <= '0;
      end else if (op_q != ST_IDLE) begin
        beat_q <= beat_q + BURST_STEP;
      end
    end
  end

  burst_addr_gen u_burst (
    .start_low(advance_or_load ? base_q[BURST_W-1:0] : addr[BURST_W-1:0]),
    .beat(advance_or_load ? beat_q + BURST_STEP : '0),
    .burst_order(order_q),
    .addr_low(addr_low)
  );
  assign cur_addr = {(advance_or_load ? base_q[ADDR_W-1:BURST_W]
                      : addr[ADDR_W-1:BURST_W]), addr_low};

  // Write data follows its address by one edge; both wait out stalls.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= '0;
      wr_lanes_q <= '0;
    end else if (qualified) begin
      wr_pend_q <= (op_d == ST_WRITE);
      rd_pend_q <= (op_d == ST_READ);
      wr_addr_q <= cur_addr;
      wr_lanes_q <= ~byte_write_lanes_n;
    end else if (sleep_q) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (qualified && wr_pend_q) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_lanes_q[i]) begin
          mem[wr_addr_q][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Registered read pipeline; data leaves one edge after acceptance.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_out <= '0;
      dq_oe <= 1'b0;
    end else if (sleep_q) begin
      dq_oe <= 1'b0;
    end else if (qualified) begin
      dq_oe <= rd_pend_q;
      if (rd_pend_q) begin
        dq_out <= mem[wr_addr_q];
      end
    end
  end

  property p_sel_decode;
    @(posedge clk) disable iff (sys_rst)
      (qualified && !advance_or_load && !selected) |=> (op_q == ST_IDLE);
  endproperty
  a_sel_decode: assert property (p_sel_decode)
    else $error("deselect did not idle the bus");

  property p_stall_holds;
    @(posedge clk) disable iff (sys_rst)
      (!qualified) |=> $stable(beat_q) && $stable(op_q);
  endproperty
  a_stall_holds: assert property (p_stall_holds)
    else $error("stall cycle changed burst state");

  property p_sleep_hiz;
    @(posedge clk) disable iff (sys_rst)
      $fell(sleep_q) |-> !dq_oe;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz)
    else $error("data pins driven on leaving sleep");

  property p_sleep_quiet;
    @(posedge clk) disable iff (sys_rst)
      sleep_q |=> !dq_oe && !wr_pend_q;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("activity during sleep");

  property p_read_pipe;
    @(posedge clk) disable iff (sys_rst)
      (qualified && op_d == ST_READ) ##1 qualified |=> dq_oe;
  endproperty
  a_read_pipe: assert property (p_read_pipe)
    else $error("read data not driven after pipeline edge");

  property p_power;
    @(posedge clk) disable iff (sys_rst)
      $rose(power_ready) |-> $past(power_cnt_q) ==
        POWER_CNT_W'(POWER_WAIT - 1);
  endproperty
  a_power: assert property (p_power)
    else $error("power wait count wrong");

  property p_write_wait;
    @(posedge clk) disable iff (sys_rst)
      (!qualified && wr_pend_q && !sleep_q) |=> wr_pend_q;
  endproperty
  a_write_wait: assert property (p_write_wait)
    else $error("pending write lost in stall");

  property p_interleave;
    @(posedge clk) disable iff (sys_rst)
      (qualified && advance_or_load && op_q != ST_IDLE && order_q) |->
        (addr_low ^ base_q[BURST_W-1:0]) == (beat_q + BURST_STEP);
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved beat address wrong");
endmodule
`default_nettype wire

/* File: sram_ctl_model.sv */
/*
  Memory controller model that drives the SRAM bus pins one cycle at a time.
  Assumes its caller runs on the same clock as the memory.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_ctl_model (
  // Clock
  input wire logic clk,
  // Pins driven toward the memory
  output logic cq_n,
  output logic [2:0] sel,
  output logic adv,
  output logic we_n,
  output logic [3:0] ln_n,
  output logic zz,
  output logic [sram_bus_pkg::ADDR_W-1:0] a,
  output logic [sram_bus_pkg::DATA_W-1:0] d
);
  initial begin
    {cq_n, sel, adv, we_n, ln_n, zz, a, d} = '0;
    sel = 3'h4;
  end
  // Pins move at the falling edge so they are steady on the rise.
  task automatic cy(input logic [2:0] s, input logic v, w, q,
    input logic [sram_bus_pkg::ADDR_W-1:0] ad,
    input logic [sram_bus_pkg::DATA_W-1:0] dd, input logic [3:0] l);
    @(negedge clk);
    {sel, adv, we_n, cq_n, a, d, ln_n} = {s, v, w, q, ad, dd, l};
  endtask
  // Sleep is only raised with the memory deselected.
  task automatic sleep(input logic on);
    @(negedge clk);
    sel = 3'h4;
    zz = on;
  endtask
endmodule
`default_nettype wire

/* File: pipelined_sram_bus_protocol_tb.sv */
/*
  Self-checking bench for the SRAM bus core with a controller model.
  Assumes a shortened power-up count, so the run waits it out once.
*/
`timescale 1ns/1ps
`default_nettype none
module pipelined_sram_bus_protocol_tb;
  import sram_bus_pkg::*;
  // Shortened power-up wait; the full count would make the run far too long.
  localparam int PWR_WAIT = 2000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap = 1'b0;
  logic cq_n, adv, we_n, zz, dq_oe, power_ready, asleep;
  logic [2:0] sel;
  logic [3:0] ln_n;
  logic [ADDR_W-1:0] a, ad;
  logic [DATA_W-1:0] d, dq_out;
  logic [2:0] sel_tab [4] = '{3'h2, 3'h6, 3'h0, 3'h3};
  logic [DATA_W-1:0] mem [int];
  int n_fail = 0;
  int check_count = 0;
  int n = 0;
  always #2.5 clk = ~clk;
  sram_ctl_model u_ctl (.clk(clk), .cq_n(cq_n), .sel(sel), .adv(adv),
    .we_n(we_n), .ln_n(ln_n), .zz(zz), .a(a), .d(d));
  sram_bus_core #(.POWER_WAIT(PWR_WAIT)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .clock_qualify_n(cq_n),
    .first_select_n(sel[2]), .second_select(sel[1]), .third_select_n(sel[0]),
    .advance_or_load(adv), .write_enable_n(we_n), .byte_write_lanes_n(ln_n),
    .sleep_request(zz), .burst_order_strap(strap), .addr(a), .dq_in(d),
    .dq_out(dq_out), .dq_oe(dq_oe), .power_ready(power_ready),
    .asleep(asleep));
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'({$urandom, $urandom});
  endfunction
  function automatic logic [DATA_W-1:0] mrg(logic [DATA_W-1:0] o, v,
    logic [3:0] l);
    for (int i = 0; i < LANES; i++)
      if (!l[i]) o[i*LANE_W +: LANE_W] = v[i*LANE_W +: LANE_W];
    return o;
  endfunction
  function automatic logic [ADDR_W-1:0] ba(logic [ADDR_W-1:0] b, int j);
    return {b[ADDR_W-1:2], strap ? b[1:0] ^ 2'(j) : b[1:0] + 2'(j)};
  endfunction
  task automatic idle(input int k);
    repeat (k) u_ctl.cy(3'h4, 1'b0, 1'b1, 1'b0, '0, rnd(), 4'hF);
  endtask
  // Write data follows the address by one qualified edge.
  task automatic wr(input logic [2:0] s, input logic q,
    input logic [ADDR_W-1:0] b, input logic [3:0] l);
    logic [DATA_W-1:0] v;
    v = rnd();
    u_ctl.cy(s, 1'b0, 1'b0, q, b, ~v, l);
    u_ctl.cy(3'h4, 1'b0, 1'b1, 1'b0, '0, v, 4'hF);
    if (s == 3'h2 && !q) mem[b] = mrg(mem[b], v, l);
  endtask
  // A stall between address and data must keep the write pending, and the
  // write offered on the stalled edge must be ignored.
  task automatic wd(input logic [ADDR_W-1:0] b, input logic [3:0] l);
    logic [DATA_W-1:0] v;
    v = rnd();
    u_ctl.cy(3'h2, 1'b0, 1'b0, 1'b0, b, ~v, l);
    u_ctl.cy(3'h2, 1'b0, 1'b0, 1'b1, b + ADDR_W'(1), ~v, 4'h0);
    u_ctl.cy(3'h4, 1'b0, 1'b1, 1'b0, '0, v, 4'hF);
    mem[b] = mrg(mem[b], v, l);
  endtask
  // Beats go out back to back; each stands from the edge after its taking.
  task automatic rb(input logic [2:0] s, input logic [ADDR_W-1:0] b,
    input int k);
    for (int i = 0; i < k + 2; i++) begin
      if (i < k) u_ctl.cy(s, i != 0, 1'b1, 1'b0, b, rnd(), 4'hF);
      else idle(1);
      if (i >= 2) begin
        chk("dq_oe", s == 3'h2, dq_oe);
        if (s == 3'h2) chk("dq_out", mem[ba(b, i - 2)], dq_out);
      end
    end
  endtask
  initial begin
    n = $urandom(32'hCF0895ED);
    n = 0;
    repeat (6) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    while (power_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > PWR_WAIT + 8) begin
        n_fail++;
        end_sim();
      end
    end
    chk("power_ready", 1'b1, n == PWR_WAIT);
    $display("power test done");
    for (int i = 0; i < 24; i++) begin
      ad = ADDR_W'($urandom & 32'h7);
      wr(sel_tab[i % 4], 1'b0, ad, mem.exists(ad) ? 4'($urandom) : 4'h0);
      rb(sel_tab[i % 4], ad, 1);
      if (mem.exists(ad)) rb(3'h2, ad, 1);
    end
    $display("select test done");
    ad = ADDR_W'(DEPTH - 4);
    for (int i = 0; i < 4; i++) wr(3'h2, 1'b0, ad + ADDR_W'(i), 4'h0);
    for (int i = 0; i < 2; i++) begin
      strap = i[0];
      idle(4);
      rb(3'h2, ad + ADDR_W'($urandom & 32'h3), 4);
    end
    $display("burst test done");
    wr(3'h2, 1'b1, ad, 4'h0);
    rb(3'h2, ad, 1);
    wd(ad, 4'($urandom));
    rb(3'h2, ad, 1);
    rb(3'h2, ad + ADDR_W'(1), 1);
    $display("stall test done");
    u_ctl.cy(3'h2, 1'b0, 1'b1, 1'b0, ad, rnd(), 4'hF);
    u_ctl.sleep(1'b1);
    idle(4);
    chk("asleep", 1'b1, asleep);
    chk("dq_oe", 1'b0, dq_oe);
    u_ctl.sleep(1'b0);
    idle(4);
    chk("dq_oe", 1'b0, dq_oe);
    rb(3'h2, ad, 1);
    $display("sleep test done");
    end_sim();
  end
endmodule
`default_nettype wire
